// ### evu_top.sv
// Exception vector numbering, table addressing and reset sequencing
`timescale 1ns/100ps
`default_nettype none
module evu_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        external_init_pin_n,
    input  wire logic        nmi_pin,
    input  wire logic        bus_busy,
    // CPU and transfer unit access checks
    input  wire logic        cpu_valid,
    input  wire logic        cpu_fetch,
    input  wire logic [1:0]  cpu_size,
    input  wire logic [31:0] cpu_addr,
    input  wire logic        cpu_periph,
    input  wire logic        cpu_periph_8bit,
    input  wire logic        dtu_valid,
    input  wire logic [1:0]  dtu_size,
    input  wire logic [31:0] dtu_addr,
    input  wire logic        dtu_periph,
    input  wire logic        dtu_periph_8bit,
    // Non-reset exception request from the core
    input  wire logic        exc_req,
    input  wire logic [2:0]  exc_kind,
    input  wire logic [7:0]  exc_num,
    input  wire logic        instr_done,
    input  wire logic [31:0] table_base_register,
    // Vector table memory port
    output logic             vec_rd,
    output logic [31:0]      vec_addr,
    input  wire logic        vec_ack,
    input  wire logic [31:0] vec_data,
    // Results
    output logic             cpu_addr_error,
    output logic             dtu_addr_error,
    output logic             core_init,
    output logic             periph_init,
    output logic             bus_controller_init,
    output logic             base_clear,
    output logic [3:0]       interrupt_mask_field,
    output logic             mask_load,
    output logic [31:0]      init_pc,
    output logic [31:0]      init_sp,
    output logic             start_exec,
    output logic             exc_push,
    output logic [31:0]      handler_pc,
    output logic             handler_valid,
    output logic             exc_busy
);
    evu_pkg::evu_state_t state;
    logic                power_on;
    logic [7:0]          vec_num;
    logic [7:0]          next_vec_num;
    logic                pending_addr_err;
    logic                pending_dtu;
    logic                manual_pend;
    logic                addr_err_taken;

    // ----------------------------------------
    // Address error detection
    // ----------------------------------------
    evu_align_check u_cpu_chk (
        .clk         (clk),
        .reset       (reset),
        .valid       (cpu_valid),
        .fetch       (cpu_fetch),
        .size        (cpu_size),
        .addr        (cpu_addr),
        .periph      (cpu_periph),
        .periph_8bit (cpu_periph_8bit),
        .error       (cpu_addr_error)
    );

    // The transfer unit never fetches instructions
    evu_align_check u_dtu_chk (
        .clk         (clk),
        .reset       (reset),
        .valid       (dtu_valid),
        .fetch       (1'b0),
        .size        (dtu_size),
        .addr        (dtu_addr),
        .periph      (dtu_periph),
        .periph_8bit (dtu_periph_8bit),
        .error       (dtu_addr_error)
    );

    // ----------------------------------------
    // Vector number for a non-reset request
    // ----------------------------------------
    always_comb
    begin
        next_vec_num = evu_pkg::VEC_ILLEGAL;
        if (pending_addr_err)
            next_vec_num = pending_dtu ? evu_pkg::VEC_DMA_ADDR : evu_pkg::VEC_CPU_ADDR;
        else
            unique case (exc_kind)
                evu_pkg::KIND_ILLEGAL: next_vec_num = evu_pkg::VEC_ILLEGAL;
                evu_pkg::KIND_SLOT:    next_vec_num = evu_pkg::VEC_SLOT;
                evu_pkg::KIND_TRAP:    next_vec_num = evu_pkg::VEC_TRAP_BASE | {3'h0, exc_num[4:0]};
                evu_pkg::KIND_NMI:     next_vec_num = evu_pkg::VEC_NMI;
                evu_pkg::KIND_BREAK:   next_vec_num = evu_pkg::VEC_BREAK;
                evu_pkg::KIND_IRQ:     next_vec_num = evu_pkg::VEC_IRQ_BASE | {5'h00, exc_num[2:0]};
                evu_pkg::KIND_ONCHIP:  next_vec_num = (exc_num < evu_pkg::VEC_ONCHIP_MIN) ?
                                           evu_pkg::VEC_ONCHIP_MIN : exc_num;
                default:               next_vec_num = evu_pkg::VEC_ILLEGAL;
            endcase
    end

    // ----------------------------------------
    // Reset type capture and hold
    // ----------------------------------------
    // Type is sampled every cycle the pin is low, so the level at release wins
    always_ff @(posedge clk)
    begin
        if (reset)
            power_on <= 1'b1;
        else if (!external_init_pin_n)
            power_on <= nmi_pin;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            manual_pend <= 1'b0;
        else if (!external_init_pin_n && !nmi_pin && bus_busy)
            manual_pend <= 1'b1;
        else if (!bus_busy)
            manual_pend <= 1'b0;
    end

    // Bus controller is left alone by manual reset so refresh keeps going
    always_comb
    begin
        core_init           = (state == evu_pkg::EVU_HOLD);
        periph_init         = core_init;
        bus_controller_init = core_init && power_on;
    end

    // ----------------------------------------
    // Latched address errors
    // ----------------------------------------
    // Besides reset and the hold state, only the read of an address error vector retires the latch, so an error
    // raised while another exception is in flight is still taken afterwards
    assign addr_err_taken = (state == evu_pkg::EVU_EXC_READ) && vec_ack &&
                            (vec_num == evu_pkg::VEC_CPU_ADDR ||
                             vec_num == evu_pkg::VEC_DMA_ADDR);

    // A new error on the retiring edge wins over the clear
    always_ff @(posedge clk)
    begin
        if (reset || state == evu_pkg::EVU_HOLD)
        begin
            pending_addr_err <= 1'b0;
            pending_dtu      <= 1'b0;
        end
        else if ((!pending_addr_err || addr_err_taken) && (cpu_addr_error || dtu_addr_error))
        begin
            pending_addr_err <= 1'b1;
            pending_dtu      <= dtu_addr_error && !cpu_addr_error;
        end
        else if (addr_err_taken)
            pending_addr_err <= 1'b0;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state   <= evu_pkg::EVU_HOLD;
            vec_num <= evu_pkg::VEC_POR_PC;
        end
        else if (!external_init_pin_n && !(manual_pend || (!nmi_pin && bus_busy)))
        begin
            state <= evu_pkg::EVU_HOLD;
        end
        else
            unique case (state)
                evu_pkg::EVU_HOLD:
                begin
                    if (external_init_pin_n)
                    begin
                        state   <= evu_pkg::EVU_READ_PC;
                        vec_num <= power_on ? evu_pkg::VEC_POR_PC : evu_pkg::VEC_MAN_PC;
                    end
                end
                evu_pkg::EVU_READ_PC:
                    if (vec_ack)
                    begin
                        state   <= evu_pkg::EVU_READ_SP;
                        vec_num <= power_on ? evu_pkg::VEC_POR_SP : evu_pkg::VEC_MAN_SP;
                    end
                evu_pkg::EVU_READ_SP:
                    if (vec_ack)
                        state <= evu_pkg::EVU_RUN;
                evu_pkg::EVU_RUN:
                    if (pending_addr_err || exc_req)
                    begin
                        state   <= evu_pkg::EVU_EXC_WAIT;
                        vec_num <= next_vec_num;
                    end
                evu_pkg::EVU_EXC_WAIT:
                    if (!bus_busy && instr_done)
                        state <= evu_pkg::EVU_EXC_READ;
                evu_pkg::EVU_EXC_READ:
                    if (vec_ack)
                        state <= evu_pkg::EVU_RUN;
                default:
                    state <= evu_pkg::EVU_HOLD;
            endcase
    end

    // ----------------------------------------
    // Vector table read port
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            vec_rd   <= 1'b0;
            vec_addr <= 32'h0000_0000;
        end
        else if (state == evu_pkg::EVU_READ_PC || state == evu_pkg::EVU_READ_SP)
        begin
            vec_rd   <= !vec_ack;
            vec_addr <= {22'h00_0000, vec_num, 2'h0};
        end
        else if (state == evu_pkg::EVU_EXC_READ)
        begin
            vec_rd   <= !vec_ack;
            vec_addr <= table_base_register + {22'h00_0000, vec_num, 2'h0};
        end
        else
            vec_rd <= 1'b0;
    end

    // ----------------------------------------
    // Results of the sequences
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            init_pc              <= 32'h0000_0000;
            init_sp              <= 32'h0000_0000;
            start_exec           <= 1'b0;
            base_clear           <= 1'b0;
            mask_load            <= 1'b0;
            interrupt_mask_field <= evu_pkg::MASK_RESET_VAL;
            handler_pc           <= 32'h0000_0000;
            handler_valid        <= 1'b0;
            exc_push             <= 1'b0;
        end
        else
        begin
            start_exec    <= 1'b0;
            base_clear    <= 1'b0;
            mask_load     <= 1'b0;
            handler_valid <= 1'b0;
            exc_push      <= 1'b0;
            if (state == evu_pkg::EVU_READ_PC && vec_ack && vec_rd)
                init_pc <= vec_data;
            if (state == evu_pkg::EVU_READ_SP && vec_ack && vec_rd)
            begin
                init_sp              <= vec_data;
                start_exec           <= 1'b1;
                base_clear           <= 1'b1;
                mask_load            <= 1'b1;
                interrupt_mask_field <= evu_pkg::MASK_RESET_VAL;
            end
            if (state == evu_pkg::EVU_EXC_WAIT && !bus_busy && instr_done)
                exc_push <= 1'b1;
            if (state == evu_pkg::EVU_EXC_READ && vec_ack && vec_rd)
            begin
                handler_pc    <= vec_data;
                handler_valid <= 1'b1;
            end
        end
    end

    assign exc_busy = (state != evu_pkg::EVU_RUN);
endmodule : evu_top
`default_nettype wire

// ### evu_pkg.sv
// Package of constants for the exception vector and reset unit
// How it works
// - Reset vector addresses are vector number times four, no base added.
// - Other exceptions address table base plus vector number times four.
// - Power-on uses vectors 0 and 1; manual reset uses 2 and 3.
// - Fixed vectors: 4, 6, 9, 10, 11, 12 for listed sources.
// - Software traps use vectors 32 to 63 from the instruction.
// - Request lines 0-7 map to 64-71; on-chip modules use 72-255.
// - Vectors 5, 7, 8 and 13-31 are never assigned.
// - Reset beats every other exception; power-on and manual types exist.
// - Init pin low with unmaskable pin high gives power-on reset.
// - Init pin low with unmaskable pin low gives manual reset.
// - On release read PC then SP, clear base, mask to F, start.
// - Manual reset runs the same sequence with its own vectors.
// - Manual reset waits for a running bus cycle to finish.
// - Bus controller keeps running through a long manual reset.
// - Instruction fetch from odd address is a CPU address error.
// - Instruction fetch from peripheral space is a CPU address error.
// - Word access at odd address is an address error.
// - Long word access off a four-byte boundary is an address error.
// - Long word access to 8-bit peripheral space is an address error.
// - Address error waits for bus cycle and instructions, pushes, branches.
package evu_pkg;
    localparam logic [7:0]  VEC_POR_PC      = 8'h00;
    localparam logic [7:0]  VEC_POR_SP      = 8'h01;
    localparam logic [7:0]  VEC_MAN_PC      = 8'h02;
    localparam logic [7:0]  VEC_MAN_SP      = 8'h03;
    localparam logic [7:0]  VEC_ILLEGAL     = 8'h04;
    localparam logic [7:0]  VEC_SLOT        = 8'h06;
    localparam logic [7:0]  VEC_CPU_ADDR    = 8'h09;
    localparam logic [7:0]  VEC_DMA_ADDR    = 8'h0A;
    localparam logic [7:0]  VEC_NMI         = 8'h0B;
    localparam logic [7:0]  VEC_BREAK       = 8'h0C;
    localparam logic [7:0]  VEC_TRAP_BASE   = 8'h20;
    localparam logic [7:0]  VEC_IRQ_BASE    = 8'h40;
    localparam logic [7:0]  VEC_ONCHIP_MIN  = 8'h48;
    localparam int          VEC_SHIFT       = 2;
    localparam logic [31:0] BASE_RESET_VAL  = 32'h0000_0000;
    localparam logic [3:0]  MASK_RESET_VAL  = 4'hF;
    localparam int          INIT_HOLD_CYC   = 20;
    localparam logic [1:0]  SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  SIZE_WORD       = 2'h1;
    localparam logic [1:0]  SIZE_LONG       = 2'h2;
    localparam logic [2:0]  KIND_ILLEGAL    = 3'h0;
    localparam logic [2:0]  KIND_SLOT       = 3'h1;
    localparam logic [2:0]  KIND_TRAP       = 3'h2;
    localparam logic [2:0]  KIND_NMI        = 3'h3;
    localparam logic [2:0]  KIND_BREAK      = 3'h4;
    localparam logic [2:0]  KIND_IRQ        = 3'h5;
    localparam logic [2:0]  KIND_ONCHIP     = 3'h6;

    typedef enum logic [2:0] {
        EVU_RUN      = 3'b000,
        EVU_HOLD     = 3'b001,
        EVU_READ_PC  = 3'b010,
        EVU_READ_SP  = 3'b011,
        EVU_EXC_WAIT = 3'b100,
        EVU_EXC_READ = 3'b101
    } evu_state_t;
endpackage : evu_pkg

// ### evu_align_check.sv
// Address error checker for one bus master
`timescale 1ns/100ps
`default_nettype none
module evu_align_check (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        valid,
    input  wire logic        fetch,
    input  wire logic [1:0]  size,
    input  wire logic [31:0] addr,
    input  wire logic        periph,
    input  wire logic        periph_8bit,
    output logic             error
);
    logic next_error;

    always_comb
    begin
        next_error = 1'b0;
        if (valid)
        begin
            if (fetch)
                next_error = addr[0] | periph;
            else if (size == evu_pkg::SIZE_WORD)
                next_error = addr[0];
            else if (size == evu_pkg::SIZE_LONG)
                next_error = (addr[1:0] != 2'h0) | (periph & periph_8bit);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            error <= 1'b0;
        else
            error <= next_error;
    end
endmodule : evu_align_check
`default_nettype wire

// ### evu_properties.sv
// Concurrent checks on the exception vector and reset unit ports
`timescale 1ns/100ps
`default_nettype none
module evu_properties (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        external_init_pin_n,
    input wire logic        nmi_pin,
    input wire logic        bus_busy,
    input wire logic        cpu_valid,
    input wire logic        cpu_fetch,
    input wire logic [1:0]  cpu_size,
    input wire logic [31:0] cpu_addr,
    input wire logic        cpu_periph,
    input wire logic        cpu_periph_8bit,
    input wire logic        dtu_valid,
    input wire logic [1:0]  dtu_size,
    input wire logic [31:0] dtu_addr,
    input wire logic        instr_done,
    input wire logic        vec_rd,
    input wire logic [31:0] vec_addr,
    input wire logic        cpu_addr_error,
    input wire logic        dtu_addr_error,
    input wire logic        core_init,
    input wire logic        periph_init,
    input wire logic        bus_controller_init,
    input wire logic        base_clear,
    input wire logic        mask_load,
    input wire logic [3:0]  interrupt_mask_field,
    input wire logic        start_exec,
    input wire logic        exc_push
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Reset sequence steps, address error flags and exception push
    // ------------------------------------------------------------
    sequence release_s;
        $rose(external_init_pin_n) && core_init;
    endsequence
    sequence pc_read_s;
        vec_rd && vec_addr[31:4] == 28'h000_0000 && vec_addr[2:0] == 3'h0;
    endsequence
    vec_align_a: assert property (vec_rd |-> vec_addr[1:0] == 2'h0)
        else $error("vector read not long aligned");
    pc_first_a: assert property (release_s |-> ##[1:4] pc_read_s)
        else $error("release did not read the pc vector");
    start_init_a: assert property (start_exec |->
        base_clear && mask_load && interrupt_mask_field == 4'hF)
        else $error("start without base clear and full mask");
    por_enter_a: assert property (!external_init_pin_n && nmi_pin |->
        ##[1:3] (core_init && bus_controller_init))
        else $error("power-on hold not entered");
    manual_hold_a: assert property (
        (!external_init_pin_n && !nmi_pin && !bus_busy)[*4] |->
        core_init && periph_init && !bus_controller_init)
        else $error("manual hold wrong");
    manual_defer_a: assert property (
        (bus_busy && !nmi_pin)[*3] ##0 !core_init |=> !core_init)
        else $error("manual reset cut a bus cycle");
    fetch_err_a: assert property (cpu_valid && cpu_fetch &&
        (cpu_addr[0] || cpu_periph) |=> cpu_addr_error)
        else $error("bad fetch not flagged");
    dtu_align_a: assert property (dtu_valid && (
        (dtu_size == evu_pkg::SIZE_WORD && dtu_addr[0]) ||
        (dtu_size == evu_pkg::SIZE_LONG && dtu_addr[1:0] != 2'h0)) |=> dtu_addr_error)
        else $error("misaligned transfer not flagged");
    periph8_a: assert property (cpu_valid && !cpu_fetch &&
        cpu_size == evu_pkg::SIZE_LONG && cpu_periph && cpu_periph_8bit |=> cpu_addr_error)
        else $error("long access to byte module not flagged");
    push_done_a: assert property (exc_push |->
        $past(instr_done) && !$past(bus_busy))
        else $error("push before bus and instructions done");
endmodule : evu_properties
`default_nettype wire

// ### evu_mem_model.sv
// Vector table memory answering long word reads, fast or slow
`timescale 1ns/100ps
`default_nettype none
module evu_mem_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        vec_rd,
    input  wire logic [31:0] vec_addr,
    output logic             vec_ack,
    output logic [31:0]      vec_data
);
    logic [3:0]  wait_cnt = 4'h0;
    logic [31:0] junk     = 32'h0000_0000;
    initial vec_ack = 1'h0;
    // Table data is made from the read address; data outside ack churns so stale reads show
    always @(posedge clk)
    begin
        junk <= junk + 32'h3C1F_0001;
        vec_ack <= 1'h0;
        vec_data <= junk;
        if (vec_rd && !vec_ack)
        begin
            if (wait_cnt == (slow ? 4'h5 : 4'h0))
            begin
                vec_ack <= 1'h1;
                vec_data <= {~vec_addr[15:0], vec_addr[15:0]};
                wait_cnt <= 4'h0;
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : evu_mem_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the exception vector and reset unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk, reset, external_init_pin_n, nmi_pin, bus_busy, slow;
    logic        cpu_valid, cpu_fetch, cpu_periph, cpu_periph_8bit, instr_done;
    logic        dtu_valid, dtu_periph, dtu_periph_8bit, exc_req, exp_c, exp_d;
    logic [1:0]  cpu_size, dtu_size;
    logic [2:0]  exc_kind;
    logic [7:0]  exc_num;
    logic [31:0] cpu_addr, dtu_addr, table_base_register, vec_addr, vec_data, r;
    logic [31:0] init_pc, init_sp, handler_pc, last_addr;
    logic        vec_rd, vec_ack, cpu_addr_error, dtu_addr_error, core_init;
    logic        periph_init, bus_controller_init, base_clear, mask_load;
    logic        start_exec, exc_push, handler_valid, exc_busy;
    logic [3:0]  interrupt_mask_field;
    integer      seed, n_fail, n_checks, n_cyc, i;

    evu_top       uut (.*);
    evu_mem_model mem (.*);

    always #25 clk = ~clk;
    // A hang is cut short well past the expected run length
    always @(posedge clk)
    begin
        n_cyc = n_cyc + 1;
        if (vec_rd && vec_ack)
            last_addr <= vec_addr;
        if (n_cyc == 20000)
        begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Expectations and shared tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] tbl(input logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction : tbl
    function automatic logic exp_err(input logic f, input logic [1:0] s,
                                     input logic [31:0] a, input logic p, input logic q);
        if (f)
            return a[0] | p;
        if (s == evu_pkg::SIZE_WORD)
            return a[0];
        return s == evu_pkg::SIZE_LONG && (a[1:0] != 2'h0 || (p && q));
    endfunction : exp_err
    task automatic chk(input logic ok, input string msg);
        n_checks = n_checks + 1;
        if (ok !== 1'h1)
        begin
            n_fail = n_fail + 1;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask : chk
    task automatic print_verdict;
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic run_reset(input logic por);
        logic [31:0] a;
        a = {22'h0, por ? evu_pkg::VEC_POR_PC : evu_pkg::VEC_MAN_PC, 2'h0};
        @(negedge clk);
        {nmi_pin, bus_busy, external_init_pin_n} = {por, !por, 1'h0};
        repeat (4) @(negedge clk);
        chk(core_init === por, "bus cycle cut");
        bus_busy = 1'h0;
        repeat (20) @(negedge clk);
        chk(core_init === 1'h1 && periph_init === 1'h1, "init");
        chk(bus_controller_init === por, "bus ctl init");
        external_init_pin_n = 1'h1;
        for (i = 0; i < 60 && start_exec !== 1'h1; i++)
            @(negedge clk);
        chk(base_clear === 1'h1 && mask_load === 1'h1 && interrupt_mask_field === 4'hF, "st");
        chk(init_pc === tbl(a) && init_sp === tbl(a + 32'h4), "vecs");
        chk(last_addr === a + 32'h4, "sp addr");
    endtask : run_reset
    task automatic run_exc(input int k, input logic [7:0] n, input logic [7:0] v);
        logic [31:0] a;
        @(negedge clk);
        table_base_register = {$random(seed)} & 32'h0000_FFFC;
        a = table_base_register + {22'h0, v, 2'h0};
        {slow, bus_busy, instr_done, exc_req} = {~slow, 2'h2, k < 7};
        {exc_kind, exc_num} = {3'(k), n};
        {cpu_valid, cpu_fetch, cpu_size, cpu_addr} = {k == 7, 3'h5, 32'h0000_1001};
        {dtu_valid, dtu_size, dtu_addr} = {k == 8, evu_pkg::SIZE_LONG, 32'h0000_2002};
        @(negedge clk);
        {exc_req, cpu_valid, dtu_valid} = 3'h0;
        repeat (3) @(negedge clk);
        chk(handler_valid === 1'h0 && exc_busy === 1'h1, "no wait");
        {bus_busy, instr_done} = 2'h1;
        @(negedge clk);
        chk(exc_push === 1'h1, "push");
        for (i = 0; i < 40 && handler_valid !== 1'h1; i++)
            @(negedge clk);
        chk(handler_valid === 1'h1 && handler_pc === tbl(a) && last_addr === a, "hdl");
    endtask : run_exc
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {seed, n_fail, n_checks, n_cyc} = {32'd84, 96'h0};
        {clk, reset, external_init_pin_n, nmi_pin, bus_busy, slow} = 6'h14;
        {cpu_valid, cpu_fetch, cpu_periph, cpu_periph_8bit, instr_done} = 5'h1;
        {dtu_valid, dtu_periph, dtu_periph_8bit, exc_req, exp_c, exp_d} = 6'h0;
        {cpu_size, dtu_size, exc_kind, exc_num} = 15'h0;
        {cpu_addr, dtu_addr, table_base_register} = 96'h0;
        repeat (16) @(negedge clk);
        reset = 1'h0;
        run_reset(1'h1);
        for (int j = 0; j < 301; j++)
        begin
            @(negedge clk);
            chk(cpu_addr_error === exp_c && dtu_addr_error === exp_d, "acc");
            r = $random(seed);
            {cpu_valid, cpu_fetch, cpu_periph, cpu_periph_8bit} = r[3:0] & {j < 300, 3'h7};
            {dtu_valid, dtu_periph, dtu_periph_8bit} = r[6:4] & {j < 300, 2'h3};
            cpu_size = r[12] ? evu_pkg::SIZE_WORD : (r[8] ? evu_pkg::SIZE_LONG : {1'h0, r[7]});
            dtu_size = r[10] ? evu_pkg::SIZE_LONG : {1'h0, r[9]};
            cpu_addr = $random(seed);
            dtu_addr = $random(seed);
            exp_c = cpu_valid &&
                    exp_err(cpu_fetch, cpu_size, cpu_addr, cpu_periph, cpu_periph_8bit);
            exp_d = dtu_valid && exp_err(1'h0, dtu_size, dtu_addr, dtu_periph, dtu_periph_8bit);
        end
        // Errors of the last draws are still in flight for a few cycles
        repeat (3) @(negedge clk);
        for (i = 0; i < 200 && exc_busy !== 1'h0; i++)
            @(negedge clk);
        run_exc(evu_pkg::KIND_ILLEGAL, 8'h00, evu_pkg::VEC_ILLEGAL);
        run_exc(evu_pkg::KIND_SLOT, 8'h00, evu_pkg::VEC_SLOT);
        run_exc(evu_pkg::KIND_NMI, 8'h00, evu_pkg::VEC_NMI);
        run_exc(evu_pkg::KIND_BREAK, 8'h00, evu_pkg::VEC_BREAK);
        run_exc(7, 8'h00, evu_pkg::VEC_CPU_ADDR);
        run_exc(8, 8'h00, evu_pkg::VEC_DMA_ADDR);
        for (int j = 0; j < 8; j++)
            run_exc(evu_pkg::KIND_IRQ, 8'(j), evu_pkg::VEC_IRQ_BASE + 8'(j));
        for (int j = 0; j < 6; j++)
        begin
            r = (j == 0) ? 32'h0000_001F : {27'h0, 5'($random(seed))};
            run_exc(evu_pkg::KIND_TRAP, r[7:0], evu_pkg::VEC_TRAP_BASE + r[7:0]);
        end
        run_exc(evu_pkg::KIND_ONCHIP, 8'hFF, 8'hFF);
        run_exc(evu_pkg::KIND_ONCHIP, 8'h10, evu_pkg::VEC_ONCHIP_MIN);
        run_reset(1'h0);
        run_reset(1'h1);
        print_verdict();
    end
endmodule : testbench
bind evu_top evu_properties chk (.*);
`default_nettype wire
